// ### hdl/rxseq_pkg.sv
// Package for the reset and exception entry sequencer.
// Assumes an 8-bit/16-bit CPU core with byte-wide memory and a 16-bit address space.
package rxseq_pkg;
    // Reset vector location, high byte first
    localparam logic [15:0] RESET_VEC_HI_ADDR = 16'h0000;
    localparam logic [15:0] RESET_VEC_LO_ADDR = 16'h0001;
    // Position of the interrupt mask bit in the condition code register
    localparam int CCR_IMASK_POS = 7;
    // Condition code register value after reset (mask bit set, rest zero)
    localparam logic [7:0] CCR_RESET = 8'h80;
    // Initial value of the program counter and stack pointer before load
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    // Least reset hold time on a running device, in system clock cycles
    localparam int RESET_HOLD_CYCLES = 10;
    // Sequencer states
    typedef enum logic [3:0] {
        RXSEQ_RESET,
        RXSEQ_VEC_HI,
        RXSEQ_VEC_LO,
        RXSEQ_FIRST,
        RXSEQ_RUN,
        RXSEQ_PUSH_PCL,
        RXSEQ_PUSH_PCH,
        RXSEQ_PUSH_CCR,
        RXSEQ_IVEC_HI,
        RXSEQ_IVEC_LO
    } rxseq_state_t;
endpackage

// ### hdl/rxseq_reset_sync.sv
// Reset conditioning for the sequencer.
// Assumes the external reset pin is synchronous to ref_clk; gives a clean internal reset.
`timescale 1ns/1ps
module rxseq_reset_sync (
    input wire logic ref_clk, // System clock
    input wire logic rstn, // Asynchronous power-on reset, active low
    input wire logic external_reset_pin_n, // Reset pin level, active low
    output logic in_reset, // High while the reset state holds
    output logic release_pulse // One cycle at leaving the reset state
);
    logic hold_q;

    // Pin low halts at once; stays combinational so the halt is not a cycle late
    assign in_reset = hold_q | ~external_reset_pin_n;

    // Remember that reset was active to mark the release edge
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            hold_q <= 1'b1;
        else
            hold_q <= ~external_reset_pin_n;
    end

    assign release_pulse = hold_q & external_reset_pin_n;
endmodule

// ### hdl/rxseq_sequencer.sv
// Reset and exception entry sequencer for a small microcontroller CPU.
// Assumes memory answers a read in the same cycle (mem_rdata valid with mem_rd).
`timescale 1ns/1ps
// Functional notes
// - Reset outranks interrupts; reset aborts any interrupt entry; irq_ack still pulses on an accept in the first pin-low cycle.
// - Reset handling starts right at reset release, waiting on nothing.
// - Interrupt entry waits for current instruction or exception handling to finish.
// - Reset pin low halts the core at once, entering reset state; a push already registered still goes out in that cycle.
// - Reset initialises CPU state, peripherals, and sets the interrupt mask bit.
// - PC loads from vector at 0000-0001, then fetching starts there.
// - All interrupts masked until the first instruction after reset completes.
// - Interrupt entry pushes program counter and condition codes onto stack.
// - With mask bit set, request flags still set but none accepted.
module rxseq_sequencer #(
    parameter int VEC_ADDR_W = 16 // Width of the vector address input
) (
    input wire logic ref_clk, // System clock, 25 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic external_reset_pin_n, // External reset pin, active low
    input wire logic irq_req, // Pending interrupt request level
    input wire logic [VEC_ADDR_W-1:0] irq_vec_addr, // Vector address of the pending interrupt
    input wire logic insn_done, // Pulse: current instruction completed
    input wire logic [15:0] general_register_seven, // Stack pointer from the core
    input wire logic [7:0] condition_code_reg, // Current condition codes from the core
    input wire logic [15:0] core_pc, // Current program counter from the core
    input wire logic [7:0] mem_rdata, // Memory read data
    output logic core_run, // Core may execute instructions
    output logic periph_reset, // Reset to on-chip peripherals
    output logic mem_rd, // Memory read strobe
    output logic mem_wr, // Memory write strobe
    output logic [15:0] mem_addr, // Memory address
    output logic [7:0] mem_wdata, // Memory write data
    output logic pc_load, // Pulse: load core PC from new_pc
    output logic [15:0] new_pc, // Program counter value to load
    output logic sp_load, // Pulse: load stack pointer from new_sp
    output logic [15:0] new_sp, // Stack pointer value to load
    output logic ccr_load, // Pulse: load condition codes from new_ccr
    output logic [7:0] new_ccr, // Condition code value to load
    output logic irq_ack // Pulse: interrupt accepted
);
    // Vector reads are two bytes, so only a 16-bit vector address can be served
    if (VEC_ADDR_W != 16)
        $error("rxseq_sequencer: VEC_ADDR_W must be 16");

    rxseq_pkg::rxseq_state_t state_q, state_d;
    logic in_reset;
    logic release_pulse;
    logic [7:0] vec_hi_q;
    logic [15:0] sp_q;
    logic [15:0] ret_pc_q;
    logic [7:0] ret_ccr_q;
    logic [15:0] ivec_q;
    logic imask;
    logic accept;

    rxseq_reset_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .external_reset_pin_n(external_reset_pin_n),
        .in_reset(in_reset),
        .release_pulse(release_pulse)
    );

    // Mask bit as seen now; flags upstream keep setting regardless
    assign imask = condition_code_reg[rxseq_pkg::CCR_IMASK_POS];

    // Accept only at an instruction boundary while running, mask clear
    assign accept = (state_q == rxseq_pkg::RXSEQ_RUN) && insn_done && irq_req && !imask;

    // Next state; a low pin overrides every state so reset always wins
    // The release cycle still counts as reset, but it must be let through to start the fetch
    always_comb
    begin
        state_d = state_q;
        if (in_reset && !release_pulse)
            state_d = rxseq_pkg::RXSEQ_RESET;
        else
        begin
            case (state_q)
                rxseq_pkg::RXSEQ_RESET:
                    if (release_pulse)
                        state_d = rxseq_pkg::RXSEQ_VEC_HI;
                rxseq_pkg::RXSEQ_VEC_HI:
                    state_d = rxseq_pkg::RXSEQ_VEC_LO;
                rxseq_pkg::RXSEQ_VEC_LO:
                    state_d = rxseq_pkg::RXSEQ_FIRST;
                // First instruction runs with interrupts held off
                rxseq_pkg::RXSEQ_FIRST:
                    if (insn_done)
                        state_d = rxseq_pkg::RXSEQ_RUN;
                rxseq_pkg::RXSEQ_RUN:
                    if (accept)
                        state_d = rxseq_pkg::RXSEQ_PUSH_PCL;
                rxseq_pkg::RXSEQ_PUSH_PCL:
                    state_d = rxseq_pkg::RXSEQ_PUSH_PCH;
                rxseq_pkg::RXSEQ_PUSH_PCH:
                    state_d = rxseq_pkg::RXSEQ_PUSH_CCR;
                rxseq_pkg::RXSEQ_PUSH_CCR:
                    state_d = rxseq_pkg::RXSEQ_IVEC_HI;
                rxseq_pkg::RXSEQ_IVEC_HI:
                    state_d = rxseq_pkg::RXSEQ_IVEC_LO;
                // Back to run; a new request waits for the next boundary
                rxseq_pkg::RXSEQ_IVEC_LO:
                    state_d = rxseq_pkg::RXSEQ_RUN;
                default:
                    state_d = rxseq_pkg::RXSEQ_RESET;
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= rxseq_pkg::RXSEQ_RESET;
        else
            state_q <= state_d;
    end

    // Capture high vector byte, used by both reset and interrupt vector loads
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            vec_hi_q <= 8'h00;
        else if (state_q == rxseq_pkg::RXSEQ_VEC_HI || state_q == rxseq_pkg::RXSEQ_IVEC_HI)
            vec_hi_q <= mem_rdata;
    end

    // Snapshot of return context taken at acceptance, so core changes cannot tear it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sp_q <= rxseq_pkg::SP_RESET;
            ret_pc_q <= rxseq_pkg::PC_RESET;
            ret_ccr_q <= rxseq_pkg::CCR_RESET;
            ivec_q <= 16'h0000;
        end
        else if (accept)
        begin
            sp_q <= general_register_seven;
            ret_pc_q <= core_pc;
            ret_ccr_q <= condition_code_reg;
            ivec_q <= irq_vec_addr;
        end
        else if (state_q == rxseq_pkg::RXSEQ_PUSH_PCL || state_q == rxseq_pkg::RXSEQ_PUSH_PCH
                 || state_q == rxseq_pkg::RXSEQ_PUSH_CCR)
            sp_q <= sp_q - 16'h0001; // Stack grows downward, pre-decrement
    end

    // Registered memory controls, one concern per block
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
        end
        else
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            case (state_d)
                rxseq_pkg::RXSEQ_VEC_HI:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= rxseq_pkg::RESET_VEC_HI_ADDR;
                end
                rxseq_pkg::RXSEQ_VEC_LO:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= rxseq_pkg::RESET_VEC_LO_ADDR;
                end
                // Push low PC, high PC, then CONDITION_CODE_REG below the stack pointer
                rxseq_pkg::RXSEQ_PUSH_PCL:
                begin
                    mem_wr <= 1'b1;
                    mem_addr <= general_register_seven - 16'h0001;
                    mem_wdata <= core_pc[7:0];
                end
                rxseq_pkg::RXSEQ_PUSH_PCH:
                begin
                    mem_wr <= 1'b1;
                    mem_addr <= sp_q - 16'h0002;
                    mem_wdata <= ret_pc_q[15:8];
                end
                rxseq_pkg::RXSEQ_PUSH_CCR:
                begin
                    mem_wr <= 1'b1;
                    mem_addr <= sp_q - 16'h0002;
                    mem_wdata <= ret_ccr_q;
                end
                rxseq_pkg::RXSEQ_IVEC_HI:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= ivec_q;
                end
                rxseq_pkg::RXSEQ_IVEC_LO:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= ivec_q + 16'h0001;
                end
                default:
                    mem_addr <= mem_addr;
            endcase
        end
    end

    // Loads into the core: PC from vectors, CONDITION_CODE_REG with mask set at reset and entry
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc_load <= 1'b0;
            new_pc <= rxseq_pkg::PC_RESET;
            ccr_load <= 1'b0;
            new_ccr <= rxseq_pkg::CCR_RESET;
            sp_load <= 1'b0;
            new_sp <= rxseq_pkg::SP_RESET;
            irq_ack <= 1'b0;
        end
        else
        begin
            pc_load <= 1'b0;
            ccr_load <= 1'b0;
            sp_load <= 1'b0;
            irq_ack <= accept;
            if (in_reset)
            begin
                // Reset image held into the core every reset cycle
                ccr_load <= 1'b1;
                new_ccr <= rxseq_pkg::CCR_RESET;
                pc_load <= 1'b1;
                new_pc <= rxseq_pkg::PC_RESET;
                sp_load <= 1'b1;
                new_sp <= rxseq_pkg::SP_RESET;
            end
            else if (state_q == rxseq_pkg::RXSEQ_VEC_LO || state_q == rxseq_pkg::RXSEQ_IVEC_LO)
            begin
                pc_load <= 1'b1;
                new_pc <= {vec_hi_q, mem_rdata};
            end
            else if (state_q == rxseq_pkg::RXSEQ_PUSH_CCR)
            begin
                // Mask further interrupts inside the handler; SP follows the pushes
                ccr_load <= 1'b1;
                new_ccr <= ret_ccr_q | rxseq_pkg::CCR_RESET;
                sp_load <= 1'b1;
                new_sp <= sp_q - 16'h0001;
            end
        end
    end

    // Core runs only outside reset and entry sequences
    assign core_run = (state_q == rxseq_pkg::RXSEQ_FIRST || state_q == rxseq_pkg::RXSEQ_RUN)
                      && !in_reset;
    // Peripherals held in reset for the whole reset state
    assign periph_reset = in_reset;
endmodule

// ### test/rxseq_asserts.sv
// Port checker for the reset and exception entry sequencer.
// Assumes one clock domain, ref_clk, with rstn as its asynchronous reset.
`timescale 1ns/1ps
module rxseq_asserts (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic external_reset_pin_n, // Reset pin
    input wire logic irq_req, // Request
    input wire logic insn_done, // Instruction end
    input wire logic [15:0] general_register_seven, // Stack pointer
    input wire logic [7:0] condition_code_reg, // Condition codes
    input wire logic [15:0] core_pc, // Return address
    input wire logic [7:0] mem_rdata, // Read data
    input wire logic core_run, // Core running
    input wire logic periph_reset, // Peripheral reset
    input wire logic mem_rd, // Read strobe
    input wire logic mem_wr, // Write strobe
    input wire logic [15:0] mem_addr, // Address
    input wire logic pc_load, // PC load
    input wire logic [15:0] new_pc, // PC value
    input wire logic sp_load, // SP load
    input wire logic ccr_load, // CONDITION_CODE_REG load
    input wire logic [7:0] new_ccr, // CONDITION_CODE_REG value
    input wire logic irq_ack // Acceptance
);
    logic first_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Open from reset until the first instruction ends; no entry may start inside it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            first_q <= 1'b1;
        else if (periph_reset)
            first_q <= 1'b1;
        else if (core_run && insn_done)
            first_q <= 1'b0;
    end
    a_pin_halts: assert property (!external_reset_pin_n |-> !core_run && periph_reset)
        else $error("core ran with the reset pin low");
    a_reset_init: assert property (rstn && !external_reset_pin_n |=> pc_load && sp_load &&
        ccr_load && new_ccr[7] && new_pc == 16'h0000) else $error("reset loads missing");
    a_vec_hi: assert property ($rose(external_reset_pin_n) ##1 external_reset_pin_n
        |-> mem_rd && mem_addr == 16'h0000) else $error("vector fetch not started");
    a_vec_load: assert property ($rose(external_reset_pin_n) ##1 external_reset_pin_n[*3]
        |-> pc_load && new_pc == {$past(mem_rdata, 2), $past(mem_rdata)})
        else $error("PC not loaded from the reset vector");
    a_first_masked: assert property (first_q && insn_done |=> !irq_ack)
        else $error("interrupt taken before the first instruction");
    a_mask_holds: assert property (insn_done && condition_code_reg[7] |=> !irq_ack)
        else $error("interrupt taken with the mask set");
    a_irq_push: assert property (core_run && !first_q && insn_done && irq_req &&
        !condition_code_reg[7] |=> irq_ack && mem_wr && mem_addr ==
        $past(general_register_seven) - 16'h0001) else $error("entry push wrong");
    a_entry_stall: assert property (irq_ack |-> !core_run[*5])
        else $error("core ran during interrupt entry");
endmodule
bind rxseq_sequencer rxseq_asserts u_chk (.*);

// ### test/rxseq_reset_src.sv
// Model of the external reset circuit driving the reset pin.
// Assumes clk_ok marks power up with a settled clock; driven just after clock edges.
`timescale 1ns/1ps
module rxseq_reset_src (
    input wire logic ref_clk, // Clock
    input wire logic clk_ok, // Power good and clock stable
    input wire logic hold_req, // Pulse: reset a running device
    output logic external_reset_pin_n // Reset pin, active low
);
    logic [3:0] cnt_q = 4'h0;
    // A running reset is never shorter than ten clocks, whatever the bench asks
    always_ff @(posedge ref_clk)
    begin
        if (hold_req)
            cnt_q <= 4'ha;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    // Low through power switching and until the clock settles
    assign external_reset_pin_n = clk_ok && cnt_q == 4'h0 && !hold_req;
endmodule

// ### test/testbench.sv
// Self-checking bench for the reset and exception entry sequencer.
// Assumes memory answers in the read cycle; each byte is its address low byte xor 3c.
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, rstn = 1'b0, clk_ok = 1'b0, hold_req = 1'b0;
    logic irq_req = 1'b0, insn_done = 1'b0, external_reset_pin_n;
    logic [15:0] general_register_seven = 16'h0, core_pc = 16'h0, irq_vec_addr = 16'h0;
    logic [7:0] condition_code_reg = 8'h80, mem_rdata, mem_wdata, new_ccr;
    logic core_run, periph_reset, mem_rd, mem_wr, pc_load, sp_load, ccr_load, irq_ack;
    logic [15:0] mem_addr, new_pc, new_sp;
    int n_fail = 0, checked = 0;
    // Rows: stack pointer, return address, condition codes, vector address
    logic [55:0] rows [4] = '{56'h0200_1234_05_0008, 56'h0100_00ff_80_000a,
        56'h0002_ff00_7f_0026, 56'h8000_abcd_c3_0010};
    function automatic logic [7:0] vb(input logic [15:0] a);
        return a[7:0] ^ 8'h3c;
    endfunction
    initial forever #20 ref_clk = ~ref_clk;
    // Outside a read the bus shows the inverse, so a stale sample cannot match
    assign mem_rdata = mem_rd ? vb(mem_addr) : ~vb(mem_addr);
    rxseq_reset_src u_rst (.*);
    rxseq_sequencer dut (.*);
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for the vector fetch, then high byte, low byte and load
    task automatic fetch_check();
        int i;
        for (i = 0; i < 40 && mem_rd !== 1'b1; i++)
            @(negedge ref_clk);
        if (i == 40)
        begin
            n_fail++;
            report_and_stop();
        end
        chk({mem_rd, mem_addr}, {1'b1, 16'h0000});
        @(negedge ref_clk);
        chk({mem_rd, mem_addr}, {1'b1, 16'h0001});
        @(negedge ref_clk);
        chk({pc_load, core_run, new_pc}, {2'b11, vb(16'h0), vb(16'h1)});
    endtask
    // One request at an instruction end; a masked row must leave no trace
    task automatic offer(input logic [55:0] r, input bit cut);
        @(posedge ref_clk);
        {general_register_seven, core_pc, condition_code_reg, irq_vec_addr} <= r;
        {irq_req, insn_done} <= 2'b11;
        @(posedge ref_clk);
        insn_done <= 1'b0;
        @(negedge ref_clk);
        if (r[23])
        begin
            chk({irq_ack, mem_wr}, 2'b00);
            return;
        end
        chk({irq_ack, mem_wr, mem_wdata, mem_addr}, {2'b11, r[31:24], r[55:40] - 16'h1});
        if (cut)
            return;
        @(negedge ref_clk);
        chk({mem_wr, mem_wdata, mem_addr}, {1'b1, r[39:32], r[55:40] - 16'h2});
        @(negedge ref_clk);
        chk({mem_wr, mem_wdata, mem_addr}, {1'b1, r[23:16], r[55:40] - 16'h3});
        @(negedge ref_clk);
        chk({mem_rd, ccr_load, sp_load, new_ccr, new_sp}, {3'b111, r[23:16] | 8'h80, r[55:40] - 16'h3});
        @(negedge ref_clk);
        chk({mem_rd, core_run, mem_addr}, {2'b10, r[15:0] + 16'h1});
        @(negedge ref_clk);
        chk({pc_load, core_run, new_pc}, {2'b11, vb(r[15:0]), vb(r[15:0] + 16'h1)});
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        chk({core_run, periph_reset, mem_rd, mem_wr, irq_ack, new_ccr}, {5'b01000, 8'h80});
        rstn <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({pc_load, sp_load, ccr_load, new_ccr, new_pc}, {3'b111, 8'h80, 16'h0});
        @(posedge ref_clk);
        clk_ok <= 1'b1;
        fetch_check();
        $display("test power_on done");
        // First instruction loads the stack pointer and ends with an unmasked request pending
        @(posedge ref_clk);
        general_register_seven <= 16'h0400;
        {condition_code_reg, irq_req, insn_done} <= {8'h00, 2'b11};
        @(posedge ref_clk);
        insn_done <= 1'b0;
        @(negedge ref_clk);
        chk({irq_ack, mem_wr, core_run}, 3'b001);
        $display("test first_insn done");
        foreach (rows[i])
            offer(rows[i], 1'b0);
        $display("test irq_rows done");
        // Reset pin drops in mid-entry: core halts at once, the high PC push in flight completes, then no further pushes
        offer(rows[0], 1'b1);
        @(posedge ref_clk);
        hold_req <= 1'b1;
        #1 chk({core_run, periph_reset}, 2'b01);
        @(posedge ref_clk);
        hold_req <= 1'b0;
        @(negedge ref_clk);
        chk({mem_wr, mem_rd, pc_load, new_pc}, {3'b001, 16'h0});
        fetch_check();
        $display("test abort done");
        report_and_stop();
    end
endmodule
